// ---- logic/osw_fault_logic.sv ----
// serial command and fault reporting logic of the octal load switch
`timescale 1ns/100ps

module osw_fault_logic #(
  parameter int FILTER_CYCLES = osw_pkg::FILTER_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic serial_clk_i,
  input wire logic chip_select_n_i,
  input wire logic serial_command_in_i,
  output logic serial_status_o,
  output logic serial_status_oe_o,
  input wire logic enable_i,
  input wire logic load_supply_ov_i,
  input wire logic logic_supply_uv_i,
  input wire logic direct_drive_five_i,
  input wire logic direct_drive_six_i,
  input wire logic [7:0] over_temp_i,
  input wire logic [7:0] over_current_i,
  input wire logic [7:0] open_load_cmp_i,
  output logic [7:0] channel_drive_o
);

  localparam int TMR_W = $clog2(FILTER_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(FILTER_CYCLES);
  localparam logic [TMR_W-1:0] TMR_ZERO = '0;
  localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // merge direct drive pins into the serial command
  function automatic logic [7:0] osw_merge_cmd(input logic [7:0] cmd,
                                               input logic d5,
                                               input logic d6);
    logic [7:0] m;
    m = cmd;
    m[osw_pkg::BIT_CH_FIVE] = cmd[osw_pkg::BIT_CH_FIVE] | d5;
    m[osw_pkg::BIT_CH_SIX] = cmd[osw_pkg::BIT_CH_SIX] | d6;
    return m;
  endfunction

  // ----------------------------------------
  // link domain: serial clock
  // ----------------------------------------
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [osw_pkg::CNT_W-1:0] count_reg;
  logic [osw_pkg::CNT_W-1:0] count_next;
  logic frame_open_reg;
  logic frame_open_next;
  logic status_bit_reg;
  logic status_bit_next;
  logic frame_tog_reg;
  logic frame_tog_next;
  logic link_clr;
  logic [7:0] snap_reg;

  // frame flags die with chip select, so nothing waits on an idle clock
  assign link_clr = reset_i | chip_select_n_i;

  // falling edge: take the next command bit, MSB first
  always_comb begin
    shift_next = shift_reg;
    count_next = count_reg;
    frame_open_next = frame_open_reg;
    frame_tog_next = frame_tog_reg;
    if (!chip_select_n_i) begin
      frame_open_next = 1'b1;
      if (frame_open_reg) begin
        shift_next = {shift_reg[6:0], serial_command_in_i};
        if (count_reg != osw_pkg::CNT_FULL) begin
          count_next = count_reg + osw_pkg::CNT_ONE;
        end
      end else begin
        // first bit: fault word leaves as command word enters
        shift_next = {snap_reg[6:0], serial_command_in_i};
        count_next = osw_pkg::CNT_ONE;
        // one flip per clocked frame; an empty select pulse leaves it still
        frame_tog_next = ~frame_tog_reg;
      end
    end
  end

  // shift word and bit count survive the frame end for the core
  always_ff @(negedge serial_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_reg <= osw_pkg::CMD_RESET;
      count_reg <= '0;
      frame_tog_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      count_reg <= count_next;
      frame_tog_reg <= frame_tog_next;
    end
  end

  // frame open flag cleared by chip select high
  always_ff @(negedge serial_clk_i or posedge link_clr) begin
    if (link_clr) begin
      frame_open_reg <= 1'b0;
    end else begin
      frame_open_reg <= frame_open_next;
    end
  end

  // rising edge: present channel eight first, then shifted bits
  always_comb begin
    if (frame_open_reg) begin
      status_bit_next = shift_reg[7];
    end else begin
      status_bit_next = snap_reg[7];
    end
  end

  // status flop falls back to zero as soon as the frame ends
  always_ff @(posedge serial_clk_i or posedge link_clr) begin
    if (link_clr) begin
      status_bit_reg <= 1'b0;
    end else begin
      status_bit_reg <= status_bit_next;
    end
  end

  assign serial_status_o = status_bit_reg;

  // ----------------------------------------
  // core domain: pin synchronisers
  // ----------------------------------------
  logic [28:0] pin_s1_reg;
  logic [28:0] pin_s2_reg;
  logic [28:0] pin_raw;
  logic cs_hist_reg;

  assign pin_raw = {chip_select_n_i, enable_i, load_supply_ov_i,
                    logic_supply_uv_i, direct_drive_five_i,
                    open_load_cmp_i, over_current_i, over_temp_i};

  // two stages for every pin; the first is read only by the second
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1_reg <= {1'b1, 28'h0000000};
      pin_s2_reg <= {1'b1, 28'h0000000};
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  logic dd6_s1_reg;
  logic dd6_s2_reg;

  // channel six drive pin, same two stages as the rest
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dd6_s1_reg <= 1'b0;
      dd6_s2_reg <= 1'b0;
    end else begin
      dd6_s1_reg <= direct_drive_six_i;
      dd6_s2_reg <= dd6_s1_reg;
    end
  end

  logic tog_s1_reg;
  logic tog_s2_reg;

  // frame toggle crosses as one bit, so no word is ever caught half changed
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
    end else begin
      tog_s1_reg <= frame_tog_reg;
      tog_s2_reg <= tog_s1_reg;
    end
  end

  logic cs_n_s;
  logic en_s;
  logic ov_s;
  logic uv_s;
  logic dd5_s;
  logic [7:0] ol_s;
  logic [7:0] oc_s;
  logic [7:0] ot_s;

  assign cs_n_s = pin_s2_reg[28];
  assign en_s = pin_s2_reg[27];
  assign ov_s = pin_s2_reg[26];
  assign uv_s = pin_s2_reg[25];
  assign dd5_s = pin_s2_reg[24];
  assign ol_s = pin_s2_reg[23:16];
  assign oc_s = pin_s2_reg[15:8];
  assign ot_s = pin_s2_reg[7:0];

  // chip select history for edge detection
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_hist_reg <= 1'b1;
    end else begin
      cs_hist_reg <= cs_n_s;
    end
  end

  logic cs_rise;
  logic cs_fall;

  assign cs_rise = cs_n_s & ~cs_hist_reg;
  assign cs_fall = ~cs_n_s & cs_hist_reg;

  // ----------------------------------------
  // core domain: command, filter timer, faults
  // ----------------------------------------
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic [TMR_W-1:0] timer_reg;
  logic [TMR_W-1:0] timer_next;
  logic [7:0] fault_reg;
  logic [7:0] fault_next;
  logic [7:0] snap_next;
  logic [7:0] cmd_eff;
  logic [7:0] fault_set;
  logic filter_done;
  logic detect_on;
  logic tog_seen_reg;
  logic tog_seen_next;
  logic frame_new;

  assign cmd_eff = osw_merge_cmd(cmd_reg, dd5_s, dd6_s2_reg);
  assign filter_done = (timer_reg == TMR_ZERO);
  // no logic supply overvoltage input exists at all
  assign detect_on = en_s & ~uv_s;
  // a select pulse with no clock edges must not reapply an old word
  assign frame_new = (tog_s2_reg != tog_seen_reg);

  // events that flag a channel this cycle
  always_comb begin
    fault_set = ot_s | oc_s;
    if (filter_done) begin
      fault_set = fault_set | (ol_s & ~cmd_eff);
    end
    if (!detect_on) begin
      fault_set = 8'h00;
    end
  end

  // command taken when a frame of at least eight bits ends
  always_comb begin
    cmd_next = cmd_reg;
    tog_seen_next = tog_seen_reg;
    if (cs_rise) begin
      tog_seen_next = tog_s2_reg;
    end
    if (uv_s) begin
      cmd_next = osw_pkg::CMD_RESET;
    end else if (cs_rise && frame_new && count_reg == osw_pkg::CNT_FULL) begin
      // the shift word is quiet once chip select is high
      cmd_next = shift_reg;
    end
  end

  // filter restarts on each chip select rise
  always_comb begin
    timer_next = timer_reg;
    if (cs_rise) begin
      timer_next = TMR_LOAD;
    end else if (!filter_done) begin
      timer_next = timer_reg - TMR_ONE;
    end
  end

  // latch faults; a read clears, but a new event wins
  always_comb begin
    fault_next = fault_reg | fault_set;
    if (uv_s) begin
      fault_next = osw_pkg::FAULT_RESET;
    end else if (cs_fall) begin
      fault_next = fault_set;
    end
  end

  // snapshot frozen while chip select is low, so the link sees a still word
  always_comb begin
    snap_next = snap_reg;
    if (uv_s) begin
      snap_next = osw_pkg::FAULT_RESET;
    end else if (cs_n_s) begin
      snap_next = fault_reg | fault_set;
    end
  end

  // command, timer and fault state
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_reg <= osw_pkg::CMD_RESET;
      timer_reg <= TMR_ZERO;
      fault_reg <= osw_pkg::FAULT_RESET;
      snap_reg <= osw_pkg::FAULT_RESET;
      tog_seen_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      timer_reg <= timer_next;
      fault_reg <= fault_next;
      snap_reg <= snap_next;
      tog_seen_reg <= tog_seen_next;
    end
  end

  // ----------------------------------------
  // core domain: output drive
  // ----------------------------------------
  logic [7:0] drive_reg;
  logic [7:0] drive_next;
  logic status_oe_reg;
  logic status_oe_next;

  // command is kept through enable, overvoltage and overtemperature shutdowns, so recovery restores it; logic undervoltage clears it
  always_comb begin
    drive_next = cmd_eff & ~ot_s;
    if (!en_s || uv_s || ov_s) begin
      drive_next = 8'h00;
    end
  end

  // status pin driven only inside a frame
  always_comb begin
    status_oe_next = ~cs_n_s & ~uv_s;
  end

  // drive and status enable outputs leave straight from this bank of flops
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      drive_reg <= 8'h00;
      status_oe_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
      status_oe_reg <= status_oe_next;
    end
  end

  assign channel_drive_o = drive_reg;
  assign serial_status_oe_o = status_oe_reg;

endmodule // osw_fault_logic

// ---- logic/osw_pkg.sv ----
// constants shared by the octal switch serial fault logic
//
// Contract
// - a 16-bit check frame returns fault status, then echoes the first byte sent
// - in long frames the last byte shifted in is applied on chip select rise
// - overtemperature shuts only its own channel, reported as a fault one
// - channel returns to commanded state after overtemperature unless commanded off
// - load supply overvoltage forces all off, then restores prior states
// - logic supply has no overvoltage detection; only load supply overvoltage drives an overvoltage shutdown
// - open load is evaluated only while the channel command bit is zero
// - chip select rise starts a 100 to 300 us filter before open load counts
// - open load fault stays latched until the host reads the status
// - thermal limit on a short cycles the channel off and on automatically
// - logic supply undervoltage turns all off and clears the fault status
// - load supply undervoltage causes no shutdown; outputs follow the command
// - each frame carries 8 command bits in and 8 fault bits out, MSB first
// - channel eight is the MSB, channel one the LSB; one means on
// - fault bit one for overtemperature, overcurrent, off-state open load only
// - serial input sampled on falling serial clock while chip select is low
// - status output undriven until chip select low, shifts on rising clock
// - direct drive inputs are ORed into channels five and six
// - enable low leaves outputs undriven, suspends detection, restores later
package osw_pkg;

  // ----------------------------------------
  // frame and word layout
  // ----------------------------------------
  localparam int CHAN_COUNT = 8;
  localparam int FRAME_BITS = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam int BIT_CH_FIVE = 4;
  localparam int BIT_CH_SIX = 5;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] FAULT_RESET = 8'h00;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CORE_CLK_KHZ = 50000;
  localparam int FILTER_TIME_US = 200;
  // whole cycles of the core clock for the open load filter
  localparam int FILTER_CYCLES = (FILTER_TIME_US * CORE_CLK_KHZ) / 1000;

endpackage

// ---- tb/osw_fault_logic_properties.sv ----
// concurrent checks on the ports of the octal switch fault logic
`timescale 1ns/100ps

module osw_fault_logic_properties #(
  parameter int FILTER_CYCLES = osw_pkg::FILTER_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic serial_clk_i,
  input wire logic chip_select_n_i,
  input wire logic serial_command_in_i,
  input wire logic serial_status_o,
  input wire logic serial_status_oe_o,
  input wire logic enable_i,
  input wire logic load_supply_ov_i,
  input wire logic logic_supply_uv_i,
  input wire logic direct_drive_five_i,
  input wire logic direct_drive_six_i,
  input wire logic [7:0] over_temp_i,
  input wire logic [7:0] over_current_i,
  input wire logic [7:0] open_load_cmp_i,
  input wire logic [7:0] channel_drive_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // status pin is only driven inside a frame, so two devices can share the line
  oe_rise_a: assert property ($fell(chip_select_n_i) |-> ##[2:5] serial_status_oe_o)
    else $error("status enable late");
  oe_cause_a: assert property ($rose(serial_status_oe_o) |-> !chip_select_n_i)
    else $error("status enable outside frame");
  oe_idle_a: assert property (chip_select_n_i [*5] |-> !serial_status_oe_o)
    else $error("status enable held");
  st_idle_a: assert property (chip_select_n_i |-> !serial_status_o)
    else $error("status not cleared");
  // shutdowns allow for the two input sync stages plus the drive register
  ov_off_a: assert property (load_supply_ov_i [*5] |-> channel_drive_o == 8'h00)
    else $error("overvoltage left drive on");
  uv_off_a: assert property (logic_supply_uv_i [*5] |-> channel_drive_o == 8'h00)
    else $error("undervoltage left drive on");
  en_off_a: assert property (!enable_i [*5] |-> channel_drive_o == 8'h00)
    else $error("disable left drive on");
  ot_off_a: assert property (over_temp_i[0] [*5] |-> !channel_drive_o[0])
    else $error("overtemperature left drive on");
  dd_five_a: assert property ((direct_drive_five_i && enable_i && !load_supply_ov_i
    && !logic_supply_uv_i && !over_temp_i[4]) [*5] |-> channel_drive_o[4])
    else $error("direct drive ignored");
  dd_six_a: assert property ((direct_drive_six_i && enable_i && !load_supply_ov_i
    && !logic_supply_uv_i && !over_temp_i[5]) [*5] |-> channel_drive_o[5])
    else $error("direct drive six ignored");
endmodule // osw_fault_logic_properties

bind osw_fault_logic osw_fault_logic_properties #(.FILTER_CYCLES(FILTER_CYCLES)) u_props (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .serial_clk_i(serial_clk_i),
  .chip_select_n_i(chip_select_n_i), .serial_command_in_i(serial_command_in_i),
  .serial_status_o(serial_status_o), .serial_status_oe_o(serial_status_oe_o),
  .enable_i(enable_i), .load_supply_ov_i(load_supply_ov_i),
  .logic_supply_uv_i(logic_supply_uv_i), .direct_drive_five_i(direct_drive_five_i),
  .direct_drive_six_i(direct_drive_six_i), .over_temp_i(over_temp_i),
  .over_current_i(over_current_i), .open_load_cmp_i(open_load_cmp_i),
  .channel_drive_o(channel_drive_o));

// ---- tb/osw_host_model.sv ----
// host side serial master driving the switch link
`timescale 1ns/100ps

module osw_host_model (
  output logic serial_clk_o,
  output logic chip_select_n_o,
  output logic serial_command_o,
  input wire logic status_i,
  input wire logic status_oe_i
);
  // link clock idles low outside frames
  initial begin
    serial_clk_o = 1'b0;
    chip_select_n_o = 1'b1;
    serial_command_o = 1'b0;
  end

  // one frame of n bits, msb first; status taken while the pin is driven
  task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] r);
    r = 16'h0000;
    chip_select_n_o = 1'b0;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      // data moves mid-low so it is steady at the falling edge
      #16 serial_command_o = d[i];
      #16 serial_clk_o = 1'b1;
      #31 r = {r[14:0], status_oe_i ? status_i : 1'bx};
      #1 serial_clk_o = 1'b0;
    end
    #32 chip_select_n_o = 1'b1;
    serial_command_o = ~serial_command_o; // released line shows no stale bit
    #120;
  endtask
endmodule // osw_host_model

// ---- tb/test_octal_switch_spi_fault_logic.sv ----
// self-checking bench for the octal switch serial fault logic
`timescale 1ns/100ps

module test_octal_switch_spi_fault_logic;
  logic core_clk_i, reset_i, sclk, cs_n, mosi, st, st_oe, en, ov, uv, dd5, dd6;
  logic [7:0] ot, oc, ol, drv;
  logic [15:0] r;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;

  osw_fault_logic #(.FILTER_CYCLES(20)) u_dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .serial_clk_i(sclk),
    .chip_select_n_i(cs_n), .serial_command_in_i(mosi), .serial_status_o(st),
    .serial_status_oe_o(st_oe), .enable_i(en), .load_supply_ov_i(ov),
    .logic_supply_uv_i(uv), .direct_drive_five_i(dd5), .direct_drive_six_i(dd6),
    .over_temp_i(ot), .over_current_i(oc), .open_load_cmp_i(ol), .channel_drive_o(drv));
  osw_host_model u_host (.serial_clk_o(sclk), .chip_select_n_o(cs_n),
    .serial_command_o(mosi), .status_i(st), .status_oe_i(st_oe));

  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  // the whole run needs about six hundred cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic fr(input logic [15:0] d, input int n);
    u_host.xfer(d, n, r);
    w(2);
  endtask
  task automatic final_report();
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset_i, en, ov, uv, dd5, dd6, ot, oc, ol} = {1'b1, 1'b1, 28'h0};
    w(5);
    reset_i = 1'b0;
    w(3);
    fr(16'hA53C, 16);
    chk("echo", r, 16'h00A5);
    chk("drive", drv, 16'h003C);
    fr(16'h0081, 8);
    chk("drive", drv, 16'h0081);
    fr(16'h000F, 4);
    chk("drive", drv, 16'h0081);
    {dd5, dd6} = 2'b11;
    w(5);
    chk("drive", drv, 16'h00B1);
    {dd5, dd6} = 2'b00;
    ot = 8'h01;
    w(5);
    chk("drive", drv, 16'h0080);
    ot = 8'h00;
    w(5);
    chk("drive", drv, 16'h0081);
    fr(16'h0081, 8);
    chk("status", r, 16'h0001);
    ov = 1'b1;
    w(5);
    chk("drive", drv, 16'h0000);
    ov = 1'b0;
    w(5);
    chk("drive", drv, 16'h0081);
    ol = 8'hFF;
    w(30);
    ol = 8'h00;
    fr(16'h0081, 8);
    chk("status", r, 16'h007E);
    fr(16'h0081, 8);
    chk("status", r, 16'h0000);
    ol = 8'hFF; // transient well inside the filter window
    w(4);
    ol = 8'h00;
    w(25);
    fr(16'h0081, 8);
    chk("status", r, 16'h0000);
    oc = 8'h02;
    w(5);
    fr(16'h0081, 8);
    chk("status", r, 16'h0002);
    uv = 1'b1;
    w(5);
    chk("drive", drv, 16'h0000);
    {oc, uv} = 9'h000;
    w(5);
    fr(16'h0000, 0); // empty select pulse must not bring back the old word
    chk("drive", drv, 16'h0000);
    fr(16'h0081, 8);
    chk("status", r, 16'h0000);
    {en, oc} = 9'h004; // overcurrent while disabled must not latch
    w(5);
    chk("drive", drv, 16'h0000);
    {en, oc} = 9'h100;
    w(5);
    chk("drive", drv, 16'h0081);
    fr(16'h0081, 8);
    chk("status", r, 16'h0000);
    final_report();
  end
endmodule // test_octal_switch_spi_fault_logic
